// *** qsr_params.svh ***
// Register map, field positions and reset values of the quick-stop reaction selector
`ifndef QSR_PARAMS_SVH
`define QSR_PARAMS_SVH

`define QSR_ADDR_W 8
`define QSR_OFS_CTRL 8'h00
`define QSR_OFS_QS_DECEL 8'h04
`define QSR_OFS_PROF_DECEL 8'h08
`define QSR_OFS_HOME_ACCEL 8'h0c
`define QSR_OFS_PT_DECEL 8'h10
`define QSR_OFS_STATUS 8'h14

`define QSR_CTRL_OPT_LSB 0
`define QSR_CTRL_OPT_MSB 3
`define QSR_CTRL_MODE_LSB 4
`define QSR_CTRL_MODE_MSB 7
`define QSR_CTRL_QS_BIT 8
`define QSR_CTRL_RELEASE_BIT 9

`define QSR_ST_STATE_LSB 0
`define QSR_ST_STATE_MSB 1
`define QSR_ST_SERVO_BIT 2
`define QSR_ST_READY_BIT 3
`define QSR_ST_BRAKE_BIT 4
`define QSR_ST_RAMP_BIT 5
`define QSR_ST_UNSUP_BIT 6
`define QSR_ST_SRC_LSB 8
`define QSR_ST_SRC_MSB 10

`define QSR_OPT_RESET 4'h2
`define QSR_MODE_RESET 4'h0
`define QSR_DECEL_RESET 32'h0000_0000

`define QSR_OPT_DB 4'h0
`define QSR_OPT_MODE_OFF 4'h1
`define QSR_OPT_QS_OFF 4'h2
`define QSR_OPT_UNSUP3 4'h3
`define QSR_OPT_UNSUP4 4'h4
`define QSR_OPT_MODE_HOLD 4'h5
`define QSR_OPT_QS_HOLD 4'h6

`endif

// *** qsr_pkg.sv ***
// Types of the quick-stop reaction selector
package qsr_pkg;

    typedef enum logic [3:0] {
        QSR_CSP = 4'h0,
        QSR_CSV = 4'h1,
        QSR_CST = 4'h2,
        QSR_PROFILE_POSITION_MODE = 4'h3,
        QSR_PROFILE_VELOCITY_MODE = 4'h4,
        QSR_PROFILE_TORQUE_MODE = 4'h5,
        QSR_CONTINUOUS_TORQUE_MODE = 4'h6,
        QSR_JOG_MODE = 4'h7,
        QSR_HOMING_MODE = 4'h8,
        QSR_POINT_TABLE_MODE = 4'h9
    } qsr_mode_t;

    typedef enum logic [1:0] {
        QSR_ST_OP_ENABLED = 2'h0,
        QSR_ST_RAMP = 2'h1,
        QSR_ST_QS_ACTIVE = 2'h2,
        QSR_ST_SW_ON_DISABLED = 2'h3
    } qsr_state_t;

    typedef enum logic [1:0] {
        QSR_REACT_NONE = 2'h0,
        QSR_REACT_BRAKE = 2'h1,
        QSR_REACT_RAMP_OFF = 2'h2,
        QSR_REACT_RAMP_HOLD = 2'h3
    } qsr_react_t;

    typedef enum logic [2:0] {
        QSR_SRC_NONE = 3'h0,
        QSR_SRC_QS_DECEL = 3'h1,
        QSR_SRC_PROF_DECEL = 3'h2,
        QSR_SRC_HOME_ACCEL = 3'h3,
        QSR_SRC_PT_DECEL = 3'h4
    } qsr_src_t;

    typedef struct packed {
        qsr_react_t kind;
        qsr_src_t src;
    } qsr_choice_t;

    typedef struct packed {
        logic servo_on;
        logic ready;
        logic dyn_brake;
        logic ramp_active;
        qsr_src_t src;
    } qsr_drive_t;

endpackage : qsr_pkg

// *** qsr_top.sv ***
// Quick-stop reaction selector with APB register slave
// What this block does
// RULE1 - Option 1: ramp down with a mode-dependent source, then remove servo power.
// RULE2 - Option 1, csp/csv: ramp with quick-stop deceleration, then Switch On Disabled.
// RULE3 - Options 1, 2, 5 in torque modes: immediate Switch On Disabled, dynamic brake.
// RULE4 - Option 1, profile position/velocity or jog: profile deceleration, then off.
// RULE5 - Option 1, homing: homing acceleration ramp, then Switch On Disabled.
// RULE6 - Option 1, point table: active entry deceleration, then Switch On Disabled.
// RULE7 - Option 2, non-torque modes: quick-stop deceleration, then Switch On Disabled.
// RULE8 - Option 5: mode-dependent ramp, then hold Quick Stop Active, servo on.
// RULE9 - Option 5, csp/csv: quick-stop deceleration, stay Quick Stop Active.
// RULE10 - Option 5, profile position/velocity or jog: profile deceleration, hold.
// RULE11 - Option 5, homing: homing acceleration ramp, stay Quick Stop Active.
// RULE12 - Option 5, point table: active entry deceleration, stay Quick Stop Active.
// RULE13 - Option 0: immediate Switch On Disabled, ready and servo off, dynamic brake.
// RULE14 - Option 6, non-torque modes: quick-stop deceleration, stay Quick Stop Active.
// RULE15 - Options 3 and 4 give no quick-stop reaction at all.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "qsr_params.svh"

module qsr_top
    import qsr_pkg::*;
(
    input wire logic ref_clk, // 25 MHz clock
    input wire logic rst_b, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [`QSR_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic qs_req_pin, // Quick-stop request from the network side
    input wire logic motor_stopped_pin, // Motor at standstill
    output qsr_drive_t drive, // Servo, ready, brake, ramp and source
    output logic [31:0] decel_value // Deceleration to use while ramping
);

    // Pin synchronisers, three stages each
    logic [2:0] qs_sync;
    logic [2:0] next_qs_sync;
    logic [2:0] stop_sync;
    logic [2:0] next_stop_sync;
    logic qs_req;
    logic next_qs_req;
    logic stopped;
    logic next_stopped;

    always_comb begin
        next_qs_sync = {qs_sync[1:0], qs_req_pin};
        next_stop_sync = {stop_sync[1:0], motor_stopped_pin};
        next_qs_req = (qs_sync[1] == qs_sync[2]) ? qs_sync[2] : qs_req;
        next_stopped = (stop_sync[1] == stop_sync[2]) ? stop_sync[2] : stopped;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            qs_sync <= 3'h0;
            stop_sync <= 3'h0;
            qs_req <= 1'b0;
            stopped <= 1'b0;
        end else begin
            qs_sync <= next_qs_sync;
            stop_sync <= next_stop_sync;
            qs_req <= next_qs_req;
            stopped <= next_stopped;
        end
    end

    // Register file and APB slave
    logic [3:0] opt_code;
    logic [3:0] next_opt_code;
    qsr_mode_t mode;
    qsr_mode_t next_mode;
    logic sw_qs;
    logic next_sw_qs;
    logic release_pulse;
    logic next_release_pulse;
    logic [31:0] qs_decel;
    logic [31:0] next_qs_decel;
    logic [31:0] prof_decel;
    logic [31:0] next_prof_decel;
    logic [31:0] home_accel;
    logic [31:0] next_home_accel;
    logic [31:0] pt_decel;
    logic [31:0] next_pt_decel;
    logic unsup;
    logic next_unsup;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic wr_en;
    logic set_unsup;
    qsr_state_t state;
    logic mapped;
    logic [31:0] status_word;

    always_comb begin
        wr_en = psel && penable && pready && pwrite;
        mapped = (paddr == `QSR_OFS_CTRL) || (paddr == `QSR_OFS_QS_DECEL) ||
                 (paddr == `QSR_OFS_PROF_DECEL) || (paddr == `QSR_OFS_HOME_ACCEL) ||
                 (paddr == `QSR_OFS_PT_DECEL) || (paddr == `QSR_OFS_STATUS);
        status_word = 32'h0;
        status_word[`QSR_ST_STATE_MSB:`QSR_ST_STATE_LSB] = state;
        status_word[`QSR_ST_SERVO_BIT] = drive.servo_on;
        status_word[`QSR_ST_READY_BIT] = drive.ready;
        status_word[`QSR_ST_BRAKE_BIT] = drive.dyn_brake;
        status_word[`QSR_ST_RAMP_BIT] = drive.ramp_active;
        status_word[`QSR_ST_UNSUP_BIT] = unsup;
        status_word[`QSR_ST_SRC_MSB:`QSR_ST_SRC_LSB] = drive.src;
        next_opt_code = opt_code;
        next_mode = mode;
        next_sw_qs = sw_qs;
        next_release_pulse = 1'b0;
        next_qs_decel = qs_decel;
        next_prof_decel = prof_decel;
        next_home_accel = home_accel;
        next_pt_decel = pt_decel;
        next_unsup = unsup;
        if (wr_en) begin
            unique case (paddr)
                `QSR_OFS_CTRL: begin
                    next_opt_code = pwdata[`QSR_CTRL_OPT_MSB:`QSR_CTRL_OPT_LSB];
                    next_mode = qsr_mode_t'(pwdata[`QSR_CTRL_MODE_MSB:`QSR_CTRL_MODE_LSB]);
                    next_sw_qs = pwdata[`QSR_CTRL_QS_BIT];
                    next_release_pulse = pwdata[`QSR_CTRL_RELEASE_BIT];
                end
                `QSR_OFS_QS_DECEL: next_qs_decel = pwdata;
                `QSR_OFS_PROF_DECEL: next_prof_decel = pwdata;
                `QSR_OFS_HOME_ACCEL: next_home_accel = pwdata;
                `QSR_OFS_PT_DECEL: next_pt_decel = pwdata;
                `QSR_OFS_STATUS: begin
                    if (pwdata[`QSR_ST_UNSUP_BIT]) begin
                        next_unsup = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // New event beats a clear in the same cycle
        if (set_unsup) begin
            next_unsup = 1'b1;
        end
        next_pready = psel && penable && !pready;
        next_pslverr = next_pready && !mapped;
        next_prdata = 32'h0;
        if (next_pready && !pwrite) begin
            unique case (paddr)
                `QSR_OFS_CTRL: begin
                    next_prdata[`QSR_CTRL_OPT_MSB:`QSR_CTRL_OPT_LSB] = opt_code;
                    next_prdata[`QSR_CTRL_MODE_MSB:`QSR_CTRL_MODE_LSB] = mode;
                    next_prdata[`QSR_CTRL_QS_BIT] = sw_qs;
                end
                `QSR_OFS_QS_DECEL: next_prdata = qs_decel;
                `QSR_OFS_PROF_DECEL: next_prdata = prof_decel;
                `QSR_OFS_HOME_ACCEL: next_prdata = home_accel;
                `QSR_OFS_PT_DECEL: next_prdata = pt_decel;
                `QSR_OFS_STATUS: next_prdata = status_word;
                default: next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            opt_code <= `QSR_OPT_RESET;
            mode <= qsr_mode_t'(`QSR_MODE_RESET);
            sw_qs <= 1'b0;
            release_pulse <= 1'b0;
            qs_decel <= `QSR_DECEL_RESET;
            prof_decel <= `QSR_DECEL_RESET;
            home_accel <= `QSR_DECEL_RESET;
            pt_decel <= `QSR_DECEL_RESET;
            unsup <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            opt_code <= next_opt_code;
            mode <= next_mode;
            sw_qs <= next_sw_qs;
            release_pulse <= next_release_pulse;
            qs_decel <= next_qs_decel;
            prof_decel <= next_prof_decel;
            home_accel <= next_home_accel;
            pt_decel <= next_pt_decel;
            unsup <= next_unsup;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Reaction lookup from option code and control mode
    function automatic qsr_choice_t pick(input logic [3:0] opt, input qsr_mode_t m);
        qsr_choice_t c;
        logic torque;
        qsr_src_t mode_src;
        c.kind = QSR_REACT_NONE;
        c.src = QSR_SRC_NONE;
        torque = (m == QSR_CST) || (m == QSR_PROFILE_TORQUE_MODE) ||
                 (m == QSR_CONTINUOUS_TORQUE_MODE);
        unique case (m)
            QSR_PROFILE_POSITION_MODE, QSR_PROFILE_VELOCITY_MODE,
            QSR_JOG_MODE: mode_src = QSR_SRC_PROF_DECEL; // [RULE4] [RULE10]
            QSR_HOMING_MODE: mode_src = QSR_SRC_HOME_ACCEL; // [RULE5] [RULE11]
            QSR_POINT_TABLE_MODE: mode_src = QSR_SRC_PT_DECEL; // [RULE6] [RULE12]
            default: mode_src = QSR_SRC_QS_DECEL; // [RULE2] [RULE9]
        endcase
        unique case (opt)
            `QSR_OPT_DB: c.kind = QSR_REACT_BRAKE; // [RULE13]
            `QSR_OPT_MODE_OFF: begin
                c.kind = torque ? QSR_REACT_BRAKE : QSR_REACT_RAMP_OFF; // [RULE1] [RULE3]
                c.src = torque ? QSR_SRC_NONE : mode_src; // [RULE1]
            end
            `QSR_OPT_QS_OFF: begin
                c.kind = torque ? QSR_REACT_BRAKE : QSR_REACT_RAMP_OFF; // [RULE3] [RULE7]
                c.src = torque ? QSR_SRC_NONE : QSR_SRC_QS_DECEL; // [RULE7]
            end
            `QSR_OPT_MODE_HOLD: begin
                c.kind = torque ? QSR_REACT_BRAKE : QSR_REACT_RAMP_HOLD; // [RULE8] [RULE3]
                c.src = torque ? QSR_SRC_NONE : mode_src; // [RULE8]
            end
            `QSR_OPT_QS_HOLD: begin
                c.kind = torque ? QSR_REACT_BRAKE : QSR_REACT_RAMP_HOLD; // [RULE14]
                c.src = torque ? QSR_SRC_NONE : QSR_SRC_QS_DECEL; // [RULE14]
            end
            default: c.kind = QSR_REACT_NONE; // [RULE15]
        endcase
        return c;
    endfunction : pick

    // Drive state machine
    qsr_state_t next_state;
    qsr_choice_t choice;
    qsr_choice_t held;
    qsr_choice_t next_held;
    qsr_drive_t next_drive;
    logic [31:0] next_decel_value;
    logic qs_any;

    always_comb begin
        qs_any = qs_req || sw_qs;
        choice = pick(opt_code, mode);
        next_state = state;
        next_held = held;
        set_unsup = 1'b0;
        unique case (state)
            QSR_ST_OP_ENABLED: begin
                if (qs_any) begin
                    next_held = choice;
                    unique case (choice.kind)
                        QSR_REACT_BRAKE: next_state = QSR_ST_SW_ON_DISABLED; // [RULE3] [RULE13]
                        QSR_REACT_RAMP_OFF,
                        QSR_REACT_RAMP_HOLD: next_state = QSR_ST_RAMP; // [RULE1] [RULE8]
                        QSR_REACT_NONE: set_unsup = 1'b1; // [RULE15]
                    endcase
                end
            end
            QSR_ST_RAMP: begin
                if (stopped) begin
                    next_state = (held.kind == QSR_REACT_RAMP_HOLD) ?
                                 QSR_ST_QS_ACTIVE : QSR_ST_SW_ON_DISABLED; // [RULE1] [RULE8]
                end
            end
            QSR_ST_QS_ACTIVE, QSR_ST_SW_ON_DISABLED: begin
                if (release_pulse && !qs_any) begin
                    next_state = QSR_ST_OP_ENABLED;
                    next_held = '{kind: QSR_REACT_NONE, src: QSR_SRC_NONE};
                end
            end
        endcase
        next_drive.servo_on = (next_state != QSR_ST_SW_ON_DISABLED); // [RULE8] [RULE13]
        next_drive.ready = (next_state != QSR_ST_SW_ON_DISABLED); // [RULE2] [RULE13]
        next_drive.dyn_brake = (next_state == QSR_ST_SW_ON_DISABLED) &&
                               (next_held.kind == QSR_REACT_BRAKE); // [RULE3] [RULE13]
        next_drive.ramp_active = (next_state == QSR_ST_RAMP);
        next_drive.src = (next_state == QSR_ST_RAMP) ? next_held.src : QSR_SRC_NONE;
        unique case (next_drive.src)
            QSR_SRC_QS_DECEL: next_decel_value = qs_decel; // [RULE2] [RULE7] [RULE9]
            QSR_SRC_PROF_DECEL: next_decel_value = prof_decel; // [RULE4] [RULE10]
            QSR_SRC_HOME_ACCEL: next_decel_value = home_accel; // [RULE5] [RULE11]
            QSR_SRC_PT_DECEL: next_decel_value = pt_decel; // [RULE6] [RULE12]
            default: next_decel_value = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= QSR_ST_OP_ENABLED;
            held <= '{kind: QSR_REACT_NONE, src: QSR_SRC_NONE};
            drive <= '{servo_on: 1'b1, ready: 1'b1, dyn_brake: 1'b0,
                       ramp_active: 1'b0, src: QSR_SRC_NONE};
            decel_value <= 32'h0;
        end else begin
            state <= next_state;
            held <= next_held;
            drive <= next_drive;
            decel_value <= next_decel_value;
        end
    end

endmodule : qsr_top
`default_nettype wire

// *** qsr_asserts.sv ***
// Port assertions of the quick-stop reaction selector
`timescale 1ns/1ps
`default_nettype none
module qsr_asserts
    import qsr_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic motor_stopped_pin, // Standstill
    input wire qsr_drive_t drive, // Drive outputs
    input wire logic [31:0] decel_value // Ramp deceleration
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    wait_state_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    ramp_drive_a: assert property (drive.ramp_active |->
        drive.src != QSR_SRC_NONE && drive.servo_on && drive.ready && !drive.dyn_brake)
        else $error("ramp with bad source or servo state");
    idle_src_a: assert property (!drive.ramp_active |->
        drive.src == QSR_SRC_NONE && decel_value == 32'h0)
        else $error("source shown outside ramp");
    brake_off_a: assert property (drive.dyn_brake |-> !drive.servo_on && !drive.ready)
        else $error("brake with servo or ready on");
    src_hold_a: assert property (drive.ramp_active && $past(drive.ramp_active)
        |-> $stable(drive.src))
        else $error("source changed in ramp");
    ramp_end_a: assert property ($rose(motor_stopped_pin) && drive.ramp_active
        |-> ##[1:6] !drive.ramp_active)
        else $error("ramp not ended after standstill");
    servo_drop_a: assert property ($fell(drive.servo_on)
        |-> drive.dyn_brake || $past(drive.ramp_active))
        else $error("servo dropped without ramp or brake");
endmodule : qsr_asserts
`default_nettype wire

// *** qsr_motion_ctl.sv ***
// Motion controller and motor model facing the selector
`timescale 1ns/1ps
`default_nettype none
module qsr_motion_ctl
    import qsr_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic req_cmd, // Bench asks for a quick stop
    input wire logic use_pin, // Request goes out on the pin
    input wire logic slow, // Long deceleration
    input wire qsr_drive_t drive, // Drive outputs
    output logic qs_req_pin, // Quick-stop request
    output logic motor_stopped_pin // Motor at standstill
);
    logic [5:0] cnt;

    // Motor reaches standstill a while after the ramp starts
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 6'h00;
            qs_req_pin <= 1'b0;
            motor_stopped_pin <= 1'b0;
        end else begin
            qs_req_pin <= req_cmd && use_pin;
            if (!req_cmd) begin
                cnt <= 6'h00;
                motor_stopped_pin <= 1'b0;
            end else begin
                if (drive.ramp_active && cnt != 6'h3f) begin
                    cnt <= cnt + 6'h01;
                end
                if (cnt == (slow ? 6'h1e : 6'h0c)) begin
                    motor_stopped_pin <= 1'b1;
                end
            end
        end
    end
endmodule : qsr_motion_ctl
`default_nettype wire

// *** tb_quick_stop_reaction_selector.sv ***
// Testbench of the quick-stop reaction selector
`timescale 1ns/1ps
`default_nettype none
module tb_quick_stop_reaction_selector
    import qsr_pkg::*;
;
    logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic req_cmd, use_pin, slow, qs_req_pin, motor_stopped_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, decel_value;
    logic [31:0] dv [4];
    logic [32:0] expq [$];
    qsr_drive_t drive;
    int mismatches = 0;
    int checked = 0;

    qsr_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .qs_req_pin(qs_req_pin), .motor_stopped_pin(motor_stopped_pin),
        .drive(drive), .decel_value(decel_value));
    qsr_motion_ctl partner (.ref_clk(ref_clk), .rst_b(rst_b), .req_cmd(req_cmd),
        .use_pin(use_pin), .slow(slow), .drive(drive), .qs_req_pin(qs_req_pin),
        .motor_stopped_pin(motor_stopped_pin));

    task automatic close_out();
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic cmp(input logic [32:0] g, input logic [32:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp

    function automatic logic [32:0] st(input logic [1:0] s, input logic [4:0] b,
        input logic [2:0] r);
        return {22'h0, r, 1'b0, b, s};
    endfunction : st

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        if (!w) expq.push_back(e);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic run(input logic [3:0] op, input logic [3:0] md);
        logic tq, un, p;
        logic [2:0] sr;
        tq = md inside {QSR_CST, QSR_PROFILE_TORQUE_MODE, QSR_CONTINUOUS_TORQUE_MODE};
        un = op inside {4'h3, 4'h4} || op > 4'h6;
        sr = (op inside {4'h2, 4'h6} || md < 4'h2) ? QSR_SRC_QS_DECEL :
            md == QSR_HOMING_MODE ? QSR_SRC_HOME_ACCEL :
            md == QSR_POINT_TABLE_MODE ? QSR_SRC_PT_DECEL : QSR_SRC_PROF_DECEL;
        p = 1'($urandom % 2);
        use_pin <= p;
        slow <= 1'($urandom % 2);
        req_cmd <= 1'b1;
        apb(1'b1, 8'h00, {23'h0, ~p, md, op}, 33'h0);
        repeat (8) @(posedge ref_clk);
        if (un) begin
            apb(1'b0, 8'h14, 32'h0, st(2'h0, 5'h13, 3'h0));
            cmp({26'h0, drive}, {26'h0, 4'b1100, 3'h0});
        end else if (op == 4'h0 || tq) begin
            apb(1'b0, 8'h14, 32'h0, st(2'h3, 5'h04, 3'h0));
            cmp({26'h0, drive}, {26'h0, 4'b0010, 3'h0});
        end else begin
            apb(1'b0, 8'h14, 32'h0, st(2'h1, 5'h0b, sr));
            cmp({26'h0, drive}, {26'h0, 4'b1101, sr});
            cmp({1'b0, decel_value}, {1'b0, dv[sr - 3'h1]});
            repeat (45) @(posedge ref_clk);
            if (op < 4'h5) begin
                apb(1'b0, 8'h14, 32'h0, st(2'h3, 5'h00, 3'h0));
                cmp({26'h0, drive}, 33'h0);
            end else begin
                apb(1'b0, 8'h14, 32'h0, st(2'h2, 5'h03, 3'h0));
                cmp({26'h0, drive}, {26'h0, 4'b1100, 3'h0});
            end
        end
        req_cmd <= 1'b0;
        repeat (6) @(posedge ref_clk);
        apb(1'b1, 8'h00, {22'h0, 2'b10, md, op}, 33'h0);
        if (un) apb(1'b1, 8'h14, 32'h40, 33'h0);
        repeat (2) @(posedge ref_clk);
        apb(1'b0, 8'h14, 32'h0, st(2'h0, 5'h03, 3'h0));
        apb(1'b0, 8'h00, 32'h0, {25'h0, md, op});
    endtask : run

    // Results are compared in order as the answers appear
    always @(posedge ref_clk) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            if (expq.size() == 0) cmp({pslverr, prdata}, 33'h1ffffffff);
            else cmp({pslverr, prdata}, expq.pop_front());
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        close_out();
    end

    initial begin
        logic [7:0] a;
        void'($urandom(6571));
        {psel, penable, pwrite, req_cmd, use_pin, slow} = 6'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst_b = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        apb(1'b0, 8'h00, 32'h0, 33'h2);
        apb(1'b0, 8'h14, 32'h0, 33'hc);
        apb(1'b0, 8'h18, 32'h0, 33'h100000000);
        for (int i = 0; i < 4; i++) begin
            a = 8'(4 * i + 4);
            dv[i] = $urandom;
            apb(1'b0, a, 32'h0, 33'h0);
            apb(1'b1, a, dv[i], 33'h0);
            apb(1'b0, a, 32'h0, {1'b0, dv[i]});
        end
        apb(1'b1, 8'h18, $urandom, 33'h0);
        apb(1'b1, 8'h14, 32'hffffffff, 33'h0);
        apb(1'b0, 8'h14, 32'h0, 33'hc);
        for (int o = 0; o < 16; o++) begin
            for (int m = 0; m < 10; m++) run(4'(o), 4'(m));
        end
        close_out();
    end
endmodule : tb_quick_stop_reaction_selector

bind qsr_top qsr_asserts chk (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_stopped_pin(motor_stopped_pin), .drive(drive), .decel_value(decel_value));
`default_nettype wire
